// ### ompd_top.sv
// on-chip rom, ram and power-down mode control
// Behaviour
// RULE1: rom on 32-bit bus, 8/16/32-bit reads from cpu or transfer unit
// RULE2: every rom read completes in one bus cycle
// RULE3: rom decodes from zero to 64k or 128k top
// RULE4: mode pins plus write protect decide rom valid; only mode 3
// RULE5: rom enabled after reset; module stop blocks access
// RULE6: ram on same 32-bit bus, single-cycle 8/16/32-bit access
// RULE7: ram contents kept in sleep and software standby
// RULE8: ram enable bit set enables ram, clear disables it
// RULE9: ram 12k from ffffd000 flash, 4k from fffff000 mask variant
// RULE10: ram operational after reset; module stop blocks but retains
// RULE11: any reset leaves controller in normal operation, all running
// RULE12: sleep stops cpu keeping registers; clocks, peripherals run
// RULE13: software standby stops clock and cpu, resets listed modules
// RULE14: module standby halts only stopped modules, reset or retained
// RULE15: reset halt initializes module; retained halt freezes registers
// RULE16: port float bit selects pin state in software standby
// RULE17: outside drives power-on and manual reset inputs
// RULE18: standby select picks sleep or standby; locked by watchdog run (code blocks only setting it; clearing still allowed)
// RULE19: port float bit 0 keeps, 1 floats; locked by watchdog run (code blocks only setting it; clearing still allowed)
// RULE20: ram enable bit is bit 0 of system control, resets to 1
// RULE21: per-module stop bits over two module stop registers
// RULE22: disabled rom or ram still answer in one cycle
module ompd_top
    import ompd_pkg::*;
#(
    parameter bit ROM_128K = 1'b0,
    parameter bit RAM_FLASH = 1'b0,
    parameter int ROM_IW = 15,
    parameter int RAM_IW = 12
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic power_on_reset_pin_n,
    input wire logic manual_reset_pin_n,
    input wire logic flash_write_protect_pin,
    input wire logic [3:0] mode_select_pins,
    input wire ompd_bus_req_t bus_req,
    output ompd_bus_rsp_t bus_rsp,
    input wire logic sleep_exec,
    input wire logic wake_event,
    input wire logic watchdog_run_bit,
    input wire logic standby_select_wr,
    input wire logic standby_select_val,
    input wire logic port_float_wr,
    input wire logic port_float_val,
    input wire logic ram_enable_wr,
    input wire logic ram_enable_val,
    input wire logic [7:0] module_stop_reg_one_wr,
    input wire logic [7:0] module_stop_reg_two_wr,
    input wire logic mstop_wr,
    output logic [7:0] system_control_reg,
    output logic [7:0] standby_control_reg,
    output logic [7:0] module_stop_reg_one,
    output logic [7:0] module_stop_reg_two,
    output ompd_mode_t power_mode,
    output logic clk_gen_run,
    output logic cpu_run,
    output logic port_pins_float,
    output logic port_pins_hold,
    output ompd_mods_t mod_run,
    output ompd_mods_t mod_reset
);
    localparam logic [7:0] STOP1_RST = 8'h00;
    localparam logic [7:0] STOP2_RST = 8'h00;

    logic standby_select_bit_q;
    logic port_float_bit_q;
    logic ram_enable_bit_q;
    logic [7:0] stop1_q;
    logic [7:0] stop2_q;
    ompd_mode_t mode_q;
    ompd_mods_t stop;
    logic any_rst;

    // external reset pins clear the stop, control and mode registers; the bus answer registers keep running
    assign any_rst = !power_on_reset_pin_n || !manual_reset_pin_n; // [RULE17]

    // stop bit map: reg one holds bus-side units, reg two memories
    assign stop.brk = stop1_q[0];
    assign stop.xfer = stop1_q[1];
    assign stop.serial = stop1_q[2];
    assign stop.adc = stop1_q[3];
    assign stop.mtimer = stop1_q[4];
    assign stop.ctimer = stop1_q[5];
    assign stop.mmtimer = stop1_q[6];
    assign stop.rom = stop2_q[0];
    assign stop.ram = stop2_q[1];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stop1_q <= STOP1_RST;
            stop2_q <= STOP2_RST;
        end else if (ce) begin
            if (any_rst) begin
                stop1_q <= STOP1_RST;
                stop2_q <= STOP2_RST;
            end else if (mstop_wr) begin
                stop1_q <= module_stop_reg_one_wr; // [RULE21]
                stop2_q <= module_stop_reg_two_wr;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            standby_select_bit_q <= OMPD_STANDBY_SELECT_BIT_RST;
            port_float_bit_q <= OMPD_HIZ_RST;
            ram_enable_bit_q <= OMPD_RAM_ENABLE_BIT_RST; // [RULE20]
        end else if (ce) begin
            if (any_rst) begin
                standby_select_bit_q <= OMPD_STANDBY_SELECT_BIT_RST;
                port_float_bit_q <= OMPD_HIZ_RST;
                ram_enable_bit_q <= OMPD_RAM_ENABLE_BIT_RST; // [RULE20]
            end else begin
                // setting refused while watchdog runs; clearing allowed
                if (standby_select_wr &&
                    !(standby_select_val && watchdog_run_bit)) begin
                    standby_select_bit_q <= standby_select_val; // [RULE18]
                end
                if (port_float_wr &&
                    !(port_float_val && watchdog_run_bit)) begin
                    port_float_bit_q <= port_float_val; // [RULE19]
                end
                if (ram_enable_wr) begin
                    ram_enable_bit_q <= ram_enable_val; // [RULE8]
                end
            end
        end
    end

    // mode controller
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= OMPD_MST_NORMAL;
        end else if (ce) begin
            if (any_rst) begin
                mode_q <= OMPD_MST_NORMAL; // [RULE11]
            end else begin
                unique case (mode_q)
                    OMPD_MST_NORMAL: begin
                        if (sleep_exec) begin
                            mode_q <= standby_select_bit_q ? // [RULE18]
                                OMPD_MST_SWSTBY : OMPD_MST_SLEEP;
                        end
                    end
                    OMPD_MST_SLEEP, OMPD_MST_SWSTBY: begin
                        if (wake_event) begin
                            mode_q <= OMPD_MST_NORMAL;
                        end
                    end
                    default: mode_q <= OMPD_MST_NORMAL;
                endcase
            end
        end
    end

    logic in_sleep, in_sw;
    assign in_sleep = mode_q == OMPD_MST_SLEEP;
    assign in_sw = mode_q == OMPD_MST_SWSTBY;

    assign power_mode = mode_q;
    assign clk_gen_run = !in_sw; // [RULE13]
    assign cpu_run = !in_sleep && !in_sw; // [RULE12]
    assign port_pins_float = in_sw && port_float_bit_q; // [RULE16]
    assign port_pins_hold = in_sw && !port_float_bit_q; // [RULE19]

    // reset-halt units: transfer, serial, converter, timers, rom
    function automatic logic rst_halt(input logic stopped);
        return stopped || in_sw;
    endfunction

    // run/reset per module; reset halt clears, retained halt freezes
    always_comb begin
        mod_reset.brk = stop.brk; // [RULE14]
        mod_run.brk = !stop.brk && !in_sw; // [RULE13]
        mod_reset.xfer = rst_halt(stop.xfer); // [RULE15]
        mod_reset.serial = rst_halt(stop.serial);
        mod_reset.adc = rst_halt(stop.adc);
        mod_reset.mtimer = rst_halt(stop.mtimer);
        mod_reset.ctimer = rst_halt(stop.ctimer);
        mod_reset.mmtimer = rst_halt(stop.mmtimer);
        mod_reset.rom = rst_halt(stop.rom); // [RULE13]
        mod_reset.ram = 1'b0; // [RULE7]
        mod_run.xfer = !mod_reset.xfer;
        mod_run.serial = !mod_reset.serial;
        mod_run.adc = !mod_reset.adc;
        mod_run.mtimer = !mod_reset.mtimer;
        mod_run.ctimer = !mod_reset.ctimer;
        mod_run.mmtimer = !mod_reset.mmtimer;
        mod_run.rom = !mod_reset.rom;
        mod_run.ram = !stop.ram && !in_sw && ram_enable_bit_q; // [RULE10]
    end

    assign system_control_reg = {2'h3, 5'h00, ram_enable_bit_q};
    assign standby_control_reg = {standby_select_bit_q, port_float_bit_q,
                                  1'h0, 4'hf, 1'h1};
    assign module_stop_reg_one = stop1_q;
    assign module_stop_reg_two = stop2_q;

    // address decode
    logic [31:0] rom_top, ram_base;
    logic mode_ok, rom_sel, ram_sel, rom_en, ram_en;
    assign rom_top = ROM_128K ? OMPD_ROM_TOP_128K : OMPD_ROM_TOP_64K;
    assign ram_base = RAM_FLASH ? OMPD_RAM_BASE_FLASH : OMPD_RAM_BASE_MASK;
    assign mode_ok = {flash_write_protect_pin, mode_select_pins}
                     == OMPD_MODE_SUPPORTED; // [RULE4]
    assign rom_sel = bus_req.addr <= rom_top; // [RULE3]
    assign ram_sel = bus_req.addr >= ram_base; // [RULE9]
    assign rom_en = mode_ok && mod_run.rom; // [RULE5]
    assign ram_en = mod_run.ram; // [RULE8]

    logic [3:0] lanes;
    assign lanes = ompd_lanes(bus_req.size, bus_req.addr[1:0]); // [RULE1]

    logic [31:0] rom_rd, ram_rd;
    logic ack_q, hit_q, src_ram_q;

    ompd_mem #(.WORDS(1 << ROM_IW), .IW(ROM_IW), .WRITABLE(1'b0)) u_rom (
        .mclk(mclk),
        .ce(ce),
        .en(bus_req.req && rom_sel && rom_en),
        .we(1'b0),
        .lanes(lanes),
        .idx(bus_req.addr[ROM_IW+1:2]),
        .wdata(bus_req.wdata),
        .init_word(32'hffff_ffff),
        .rdata(rom_rd)
    );

    // ram keeps contents whenever not accessed; nothing clears it [RULE7]
    ompd_mem #(.WORDS(1 << RAM_IW), .IW(RAM_IW), .WRITABLE(1'b1)) u_ram (
        .mclk(mclk),
        .ce(ce),
        .en(bus_req.req && ram_sel && ram_en),
        .we(bus_req.wr),
        .lanes(lanes), // [RULE6]
        .idx(bus_req.addr[RAM_IW+1:2]),
        .wdata(bus_req.wdata),
        .init_word(32'h0000_0000),
        .rdata(ram_rd)
    );

    // one-cycle answer for every request, hit or blocked
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            hit_q <= 1'b0;
            src_ram_q <= 1'b0;
        end else if (ce) begin
            ack_q <= bus_req.req; // [RULE2] [RULE22]
            hit_q <= bus_req.req && ((rom_sel && rom_en && !bus_req.wr)
                     || (ram_sel && ram_en));
            src_ram_q <= ram_sel;
        end
    end

    assign bus_rsp.ack = ack_q;
    assign bus_rsp.hit = hit_q;
    assign bus_rsp.rdata = !hit_q ? 32'h0000_0000 :
                           (src_ram_q ? ram_rd : rom_rd);

    a_one_cycle_ack: assert property ( // [RULE2]
        @(posedge mclk) disable iff (!rstn)
        ce && bus_req.req |=> bus_rsp.ack)
        else $error("access not answered in one cycle");
    a_reset_normal: assert property ( // [RULE11]
        @(posedge mclk) disable iff (!rstn)
        ce && any_rst |=> power_mode == OMPD_MST_NORMAL && cpu_run)
        else $error("reset did not return to normal");
    a_standby_select_bit_lock: assert property ( // [RULE18]
        @(posedge mclk) disable iff (!rstn)
        ce && !any_rst && watchdog_run_bit && !standby_select_bit_q
        |=> !standby_select_bit_q)
        else $error("standby select set while watchdog runs");
    a_hiz_lock: assert property ( // [RULE19]
        @(posedge mclk) disable iff (!rstn)
        ce && watchdog_run_bit && !port_float_bit_q |=> !port_float_bit_q)
        else $error("port float set while watchdog runs");
    a_sleep_cpu: assert property ( // [RULE12]
        @(posedge mclk) disable iff (!rstn)
        power_mode == OMPD_MST_SLEEP |-> !cpu_run && clk_gen_run
        && mod_run.serial == !stop.serial)
        else $error("sleep mode state wrong");
    a_swstby_state: assert property ( // [RULE13]
        @(posedge mclk) disable iff (!rstn)
        power_mode == OMPD_MST_SWSTBY |-> !clk_gen_run && mod_reset.xfer
        && mod_reset.rom && !mod_reset.ram && !mod_run.brk)
        else $error("software standby state wrong");
    a_rom_block: assert property ( // [RULE5]
        @(posedge mclk) disable iff (!rstn)
        ce && bus_req.req && rom_sel && stop.rom |=> bus_rsp.ack
        && !bus_rsp.hit)
        else $error("stopped rom answered as hit");
    a_ram_enable: assert property ( // [RULE8]
        @(posedge mclk) disable iff (!rstn)
        ce && bus_req.req && ram_sel && !ram_enable_bit_q |=> !bus_rsp.hit)
        else $error("disabled ram answered as hit");
    a_mode_ok: assert property ( // [RULE4]
        @(posedge mclk) disable iff (!rstn)
        ce && bus_req.req && rom_sel && !mode_ok |=> bus_rsp.ack
        && !bus_rsp.hit)
        else $error("rom answered in unsupported mode");
endmodule

// ### ompd_pkg.sv
// shared constants and types for the memory and power-down block
package ompd_pkg;
    localparam int OMPD_DW = 32;
    localparam int OMPD_AW = 32;
    localparam logic [31:0] OMPD_ROM_BASE = 32'h0000_0000;
    localparam logic [31:0] OMPD_ROM_TOP_64K = 32'h0000_ffff;
    localparam logic [31:0] OMPD_ROM_TOP_128K = 32'h0001_ffff;
    localparam logic [31:0] OMPD_RAM_BASE_FLASH = 32'hffff_d000;
    localparam logic [31:0] OMPD_RAM_BASE_MASK = 32'hffff_f000;
    localparam logic [31:0] OMPD_MEM_TOP = 32'hffff_ffff;
    localparam logic [4:0] OMPD_MODE_SUPPORTED = 5'h03;
    localparam logic [1:0] OMPD_SZ_BYTE = 2'h0;
    localparam logic [1:0] OMPD_SZ_HALF = 2'h1;
    localparam logic [1:0] OMPD_SZ_WORD = 2'h2;
    localparam logic OMPD_RAM_ENABLE_BIT_RST = 1'h1;
    localparam logic OMPD_STANDBY_SELECT_BIT_RST = 1'h0;
    localparam logic OMPD_HIZ_RST = 1'h0;
    localparam logic OMPD_STANDBY_SLEEP = 1'h0;
    localparam logic OMPD_STANDBY_SOFT = 1'h1;

    typedef enum logic [1:0] {
        OMPD_MST_NORMAL,
        OMPD_MST_SLEEP,
        OMPD_MST_SWSTBY
    } ompd_mode_t;

    typedef struct packed {
        logic req;
        logic wr;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ompd_bus_req_t;

    typedef struct packed {
        logic ack;
        logic hit;
        logic [31:0] rdata;
    } ompd_bus_rsp_t;

    typedef struct packed {
        logic brk;
        logic xfer;
        logic serial;
        logic adc;
        logic mtimer;
        logic ctimer;
        logic mmtimer;
        logic rom;
        logic ram;
    } ompd_mods_t;

    // byte-lane enables from size and low address bits
    function automatic logic [3:0] ompd_lanes(input logic [1:0] size,
                                              input logic [1:0] a);
        logic [3:0] l;
        l = 4'h0;
        unique case (size)
            OMPD_SZ_BYTE: l = 4'h1 << a;
            OMPD_SZ_HALF: l = a[1] ? 4'hc : 4'h3;
            default: l = 4'hf;
        endcase
        return l;
    endfunction
endpackage

// ### ompd_mem.sv
// word memory with byte lanes and registered read data
module ompd_mem
    import ompd_pkg::*;
#(
    parameter int WORDS = 1024,
    parameter int IW = 10,
    parameter bit WRITABLE = 1'b1
) (
    input wire logic mclk,
    input wire logic ce,
    input wire logic en,
    input wire logic we,
    input wire logic [3:0] lanes,
    input wire logic [IW-1:0] idx,
    input wire logic [31:0] wdata,
    input wire logic [31:0] init_word,
    output logic [31:0] rdata
);
    // one byte-wide array per lane, so each lane has a single writer
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            logic [7:0] cells [WORDS];
            logic [7:0] rd_q;
            always_ff @(posedge mclk) begin
                if (ce && en && we && WRITABLE && lanes[g]) begin
                    cells[idx] <= wdata[8*g +: 8];
                end
            end
            // unprogrammed rom reads as the init pattern
            always_ff @(posedge mclk) begin
                if (ce && en) begin
                    rd_q <= WRITABLE ? cells[idx] : init_word[8*g +: 8];
                end
            end
        end
    endgenerate

    assign rdata = {g_lane[3].rd_q, g_lane[2].rd_q, g_lane[1].rd_q,
                    g_lane[0].rd_q};
endmodule

// ### ompd_cpu_model.sv
// bus master model for the cpu and transfer controller side
module ompd_cpu_model
    import ompd_pkg::*;
(
    input wire logic mclk,
    output ompd_bus_req_t bus_req,
    input wire ompd_bus_rsp_t bus_rsp
);
    timeunit 1ns;
    timeprecision 100ps;
    logic chain;
    logic ack_seen;
    logic hit_seen;
    logic [31:0] rd_seen;
    time rel_t;
    initial begin
        bus_req = '0;
        chain = 1'b0;
        rel_t = '1;
    end
    // request held over its taking edge, answer read one cycle on
    task automatic xfer(input logic wr, input logic [1:0] size,
                        input logic [31:0] addr, input logic [31:0] wd);
        // idle edge after a release so req never toggles in one step
        if ($time == rel_t) begin
            @(posedge mclk);
            #2;
        end
        bus_req = '{req: 1'b1, wr: wr, size: size, addr: addr,
                    wdata: wd};
        @(posedge mclk);
        #2;
        ack_seen = bus_rsp.ack;
        hit_seen = bus_rsp.hit;
        rd_seen = bus_rsp.rdata;
        // released lines carry inverted wr, addr and data; size keeps its old value
        if (!chain) begin
            bus_req = '{req: 1'b0, wr: ~wr, size: size, addr: ~addr,
                        wdata: ~wd};
            rel_t = $time;
        end
    endtask
endmodule

// ### tb.sv
// self-checking bench for the memory and power-down block
module tb
    import ompd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rstn, ce, power_on_reset_pin_n, manual_reset_pin_n;
    logic flash_write_protect_pin, sleep_exec, wake_event, watchdog_run_bit;
    logic standby_select_wr, standby_select_val, port_float_wr;
    logic port_float_val, ram_enable_wr, ram_enable_val, mstop_wr;
    logic [3:0] mode_select_pins;
    logic [7:0] module_stop_reg_one_wr, module_stop_reg_two_wr;
    logic [7:0] system_control_reg, standby_control_reg;
    logic [7:0] module_stop_reg_one, module_stop_reg_two;
    logic clk_gen_run, cpu_run, port_pins_float, port_pins_hold;
    ompd_bus_req_t bus_req;
    ompd_bus_rsp_t bus_rsp;
    ompd_mode_t power_mode;
    ompd_mods_t mod_run, mod_reset;
    int miscompares = 0;
    int compares = 0;
    localparam logic [31:0] RB = OMPD_RAM_BASE_MASK;
    localparam logic [1:0] SB = OMPD_SZ_BYTE;
    localparam logic [1:0] SH = OMPD_SZ_HALF;
    localparam logic [1:0] SW = OMPD_SZ_WORD;

    ompd_top dut (.mclk, .rstn, .ce, .power_on_reset_pin_n,
        .manual_reset_pin_n, .flash_write_protect_pin, .mode_select_pins,
        .bus_req, .bus_rsp, .sleep_exec, .wake_event, .watchdog_run_bit,
        .standby_select_wr, .standby_select_val, .port_float_wr,
        .port_float_val, .ram_enable_wr, .ram_enable_val,
        .module_stop_reg_one_wr, .module_stop_reg_two_wr, .mstop_wr,
        .system_control_reg, .standby_control_reg, .module_stop_reg_one,
        .module_stop_reg_two, .power_mode, .clk_gen_run, .cpu_run,
        .port_pins_float, .port_pins_hold, .mod_run, .mod_reset);
    ompd_cpu_model cpu (.mclk, .bus_req, .bus_rsp);

    always #12.5 mclk = ~mclk;

    task automatic step();
        @(posedge mclk);
        #2;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [1:0] sz,
        input logic [31:0] a, input logic [31:0] wd, input logic eh,
        input logic [31:0] er, input logic cr);
        cpu.xfer(wr, sz, a, wd);
        chk(cpu.ack_seen, 1);
        chk(cpu.hit_seen, eh);
        if (cr) chk(cpu.rd_seen, er);
    endtask
    // {select wr,val, float wr,val, ram enable wr,val}
    task automatic ctl(input logic [5:0] v);
        {standby_select_wr, standby_select_val, port_float_wr,
         port_float_val, ram_enable_wr, ram_enable_val} = v;
        step();
        {standby_select_wr, port_float_wr, ram_enable_wr} = 3'h0;
        step();
    endtask
    task automatic mstop(input logic [15:0] v);
        {module_stop_reg_one_wr, module_stop_reg_two_wr} = v;
        mstop_wr = 1'b1;
        step();
        mstop_wr = 1'b0;
        step();
    endtask
    task automatic t_reset();
        chk(system_control_reg[0], 1);
        chk(power_mode, OMPD_MST_NORMAL);
        chk({clk_gen_run, cpu_run}, 2'h3);
        chk(mod_run, 9'h1ff);
        chk({module_stop_reg_one, module_stop_reg_two}, 16'h0);
        chk(standby_control_reg[7:6], 2'h0);
    endtask
    task automatic t_ram();
        cpu.chain = 1'b1;
        acc(1, SW, RB, 32'h11223344, 1, 0, 0);
        acc(1, SB, RB + 2, 32'h99aa7766, 1, 0, 0);
        acc(1, SH, RB, 32'hdeadbeef, 1, 0, 0);
        acc(0, SW, RB, 0, 1, 32'h11aabeef, 1);
        acc(1, SW, OMPD_MEM_TOP - 3, 32'h5a5a0f0f, 1, 0, 0);
        acc(0, SW, OMPD_MEM_TOP - 3, 0, 1, 32'h5a5a0f0f, 1);
        acc(0, SW, RB - 4, 0, 0, 0, 1);
        cpu.chain = 1'b0;
        acc(0, SW, 32'h8000_0000, 0, 0, 0, 1);
    endtask
    task automatic t_rom();
        for (int s = 0; s < 3; s++) begin
            acc(0, s[1:0], 32'h2, 0, 1, 32'hffffffff, 1);
        end
        acc(0, SW, OMPD_ROM_TOP_64K - 3, 0, 1, 32'hffffffff, 1);
        acc(0, SW, OMPD_ROM_TOP_64K + 1, 0, 0, 0, 1);
        acc(1, SW, 32'h0, 32'h1, 0, 0, 0);
    endtask
    task automatic t_ram_en();
        ctl(6'b000010);
        chk(system_control_reg[0], 0);
        acc(0, SW, RB, 0, 0, 0, 1);
        acc(1, SW, RB, 32'hffffffff, 0, 0, 0);
        ctl(6'b000011);
        acc(0, SW, RB, 0, 1, 32'h11aabeef, 1);
    endtask
    task automatic t_mstop();
        logic [8:0] m;
        logic [8:0] mn;
        for (int k = 0; k < 9; k++) begin
            m = 9'h100 >> k;
            mn = ~m;
            mstop((k < 7) ? {8'h01 << k, 8'h00} : {8'h00, 8'h01 << (k - 7)});
            chk(mod_run, mn);
            chk(mod_reset, (k == 8) ? 9'h000 : m);
            if (k == 7) acc(0, SW, 32'h0, 0, 0, 0, 1);
            if (k == 8) acc(0, SW, RB, 0, 0, 0, 1);
        end
        mstop(16'h0);
        acc(0, SW, RB, 0, 1, 32'h11aabeef, 1);
        acc(0, SW, 32'h0, 0, 1, 0, 0);
    endtask
    task automatic enter_wake(input logic wake);
        if (wake) wake_event = 1'b1;
        else sleep_exec = 1'b1;
        step();
        {sleep_exec, wake_event} = 2'h0;
    endtask
    task automatic t_sleep();
        enter_wake(0);
        chk(power_mode, OMPD_MST_SLEEP);
        chk({clk_gen_run, cpu_run}, 2'h2);
        chk(mod_run, 9'h1ff);
        acc(0, SW, RB, 0, 1, 32'h11aabeef, 1);
        enter_wake(1);
        chk(power_mode, OMPD_MST_NORMAL);
    endtask
    task automatic t_freeze();
        ce = 1'b0;
        mstop(16'h00ff);
        enter_wake(0);
        ce = 1'b1;
        chk({module_stop_reg_one, module_stop_reg_two}, 16'h0);
        chk(power_mode, OMPD_MST_NORMAL);
    endtask
    task automatic t_standby();
        watchdog_run_bit = 1'b1;
        ctl(6'b111100);
        chk(standby_control_reg[7:6], 2'h0);
        watchdog_run_bit = 1'b0;
        for (int f = 0; f < 2; f++) begin
            ctl({3'b111, f[0], 2'b00});
            chk(standby_control_reg[7:6], {1'b1, f[0]});
            enter_wake(0);
            chk(power_mode, OMPD_MST_SWSTBY);
            chk({clk_gen_run, cpu_run}, 2'h0);
            chk({port_pins_float, port_pins_hold},
                {f[0], ~f[0]});
            chk({mod_reset.xfer, mod_reset.serial, mod_reset.rom,
                 mod_reset.ram, mod_reset.brk, mod_run.brk},
                6'h38);
            acc(0, SW, RB, 0, 0, 0, 1);
            enter_wake(1);
            acc(0, SW, RB, 0, 1, 32'h11aabeef, 1);
        end
        ctl(6'b101000);
    endtask
    task automatic t_pins();
        for (int m = 0; m < 3; m++) begin
            ctl(6'b111110);
            mstop(16'h7f03);
            enter_wake(0);
            {flash_write_protect_pin, mode_select_pins} =
                (m == 0) ? 5'h02 : (m == 1) ? 5'h13 : 5'h03;
            if (m == 1) manual_reset_pin_n = 1'b0;
            else power_on_reset_pin_n = 1'b0;
            step();
            {manual_reset_pin_n, power_on_reset_pin_n} = 2'h3;
            t_reset();
            acc(0, SW, 32'h0, 0, m == 2, 0, 0);
        end
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        {rstn, ce, power_on_reset_pin_n, manual_reset_pin_n} = 4'h7;
        {flash_write_protect_pin, mode_select_pins} = 5'h03;
        {sleep_exec, wake_event, watchdog_run_bit, mstop_wr} = 4'h0;
        {standby_select_wr, standby_select_val, port_float_wr} = 3'h0;
        {port_float_val, ram_enable_wr, ram_enable_val} = 3'h1;
        {module_stop_reg_one_wr, module_stop_reg_two_wr} = 16'h0;
        repeat (3) @(posedge mclk);
        #2;
        rstn = 1'b1;
        t_reset();
        t_ram();
        t_rom();
        t_ram_en();
        t_mstop();
        t_sleep();
        t_freeze();
        t_standby();
        t_pins();
        end_of_test();
    end
    // cut a hang short well past the expected hundred or so cycles
    initial begin
        #50000;
        miscompares++;
        end_of_test();
    end
endmodule
